// ===== logic/rpc_record_path_regs.v
// Function
// [R1] Slot field puts ADC pair on TDM pairs one to four; eight slots allow all.
// [R2] Software sets slot pair together with the ADC channel-order bit.
// [R3] Invert bit negates ADC samples; clear passes them unchanged.
// [R4] High-pass bit filters ADC path; cutoff 2 Hz at 48 kHz, scales with rate.
// [R5] Mic polarity bit: 0 low level is a pulse, 1 high level is.
// [R6] Swap bit 0: left on rising, right on falling edge; 1 reversed.
// [R7] Mic select turns ADCs off, drives bit clock at 128 fs, interleaved data.
// [R8] Software sets mic select before mics, clears it before ADCs.
// [R9] ADC enable field powers left and right individually; resets both off.
// [R10] Attenuator code times 0.375 dB, 0 to -95.625 dB, 256 steps.
// [R11] Applied attenuation slews one 0.375 dB step per audio frame.
// [R12] DAC mute bits act immediately on write completion, no slew.
// [R13] Software ramps output down before a hard DAC mute.
// [R14] With detector on, new beep gain waits for zero crossing or timeout.
// [R15] Software raises beep gain at most one 3 dB step per write.
// [R16] Detector enable bit 0; off means beep gain applies at once.
// [R17] Two-bit timeout field sets wait for a beep zero crossing; code decodes zc_ctrl[4:3], outside its 3 bits, so the field is ignored.
// [R18] DAC mute bits active low, reset to 0 so channels start muted.
// [R19] Beep code 0 mutes, 1 to 8 give -15 to +6 dB, others reserved.
`timescale 1ns/1ps
`include "rpc_defs.vh"
module rpc_record_path_regs #(
    parameter DW        = 24,
    parameter BCLK_HALF = `RPC_BCLK_HALF,
    parameter HPF_SHIFT = `RPC_HPF_SHIFT
) (
    input  wire          mclk,
    input  wire          resetn,
    input  wire [16:0]   avs_address,
    input  wire          avs_read,
    input  wire          avs_write,
    input  wire [31:0]   avs_writedata,
    input  wire [3:0]    avs_byteenable,
    output reg  [31:0]   avs_readdata,
    output reg           avs_waitrequest,
    input  wire          tdm_eight_slots,
    input  wire          frame_tick,
    input  wire          beep_zero_cross,
    input  wire          record_data_line,
    input  wire          s_valid,
    output reg           s_ready,
    input  wire [DW-1:0] s_left,
    input  wire [DW-1:0] s_right,
    output reg           m_valid,
    input  wire          m_ready,
    output reg  [DW-1:0] m_left,
    output reg  [DW-1:0] m_right,
    output reg  [1:0]    adc_slot_pair,
    output reg           adc_left_power,
    output reg           adc_right_power,
    output reg           mic_bclk_out,
    output reg           mic_bclk_oe,
    output reg           pdm_left,
    output reg           pdm_right,
    output reg           pdm_strobe,
    output reg           dac_left_unmute,
    output reg           dac_right_unmute,
    output reg  [3:0]    beep_gain_left,
    output reg  [3:0]    beep_gain_right
);
    reg  [1:0]    slot_sel;
    reg  [6:0]    adc_ctrl;
    reg  [7:0]    att_tgt_l;
    reg  [7:0]    att_tgt_r;
    reg  [7:0]    att_cur_l;
    reg  [7:0]    att_cur_r;
    reg  [3:0]    beep_l;
    reg  [3:0]    beep_r;
    reg  [2:0]    zc_ctrl;
    reg  [7:0]    zc_count;
    reg  [7:0]    bclk_cnt;
    reg  [DW-1:0] dc_l;
    reg  [DW-1:0] dc_r;
    reg  [DW-1:0] skid_l;
    reg  [DW-1:0] skid_r;
    reg           skid_valid;
    reg  [7:0]    timeout;
    reg  [31:0]   next_readdata;
    wire [14:0]   idx;
    wire          wr_lo;
    wire          take;
    wire          mic_sel;
    wire          beep_pending;
    wire          pdm_pulse;
    wire [DW-1:0] pre_l;
    wire [DW-1:0] pre_r;
    wire [DW-1:0] out_l;
    wire [DW-1:0] out_r;

    assign idx     = avs_address[16:2];
    assign wr_lo   = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign take    = s_valid && s_ready;
    assign mic_sel = adc_ctrl[`RPC_B_MIC_SEL];

    // Gain 2^(-k/16) in Q1.15
    function [15:0] frac_gain;
        input [3:0] k;
        begin
            case (k)
                4'h0: frac_gain = 16'h8000;
                4'h1: frac_gain = 16'h7A93;
                4'h2: frac_gain = 16'h7560;
                4'h3: frac_gain = 16'h7066;
                4'h4: frac_gain = 16'h6BA2;
                4'h5: frac_gain = 16'h6712;
                4'h6: frac_gain = 16'h62B4;
                4'h7: frac_gain = 16'h5E84;
                4'h8: frac_gain = 16'h5A82;
                4'h9: frac_gain = 16'h56AC;
                4'hA: frac_gain = 16'h52FF;
                4'hB: frac_gain = 16'h4F7B;
                4'hC: frac_gain = 16'h4C1C;
                4'hD: frac_gain = 16'h48E2;
                4'hE: frac_gain = 16'h45CB;
                default: frac_gain = 16'h42D5;
            endcase
        end
    endfunction

    // Polarity and high-pass
    function [DW-1:0] pre_proc;
        input [DW-1:0] x;
        input [DW-1:0] dc;
        input          inv;
        input          hpf;
        reg   [DW-1:0] v;
        begin
            v = inv ? (~x + 1'b1) : x; // R3
            pre_proc = hpf ? (v - dc) : v; // R4
        end
    endfunction

    // Code k attenuates by k times 0.375 dB: 6 dB per 16 codes
    function [DW-1:0] attenuate;
        input [DW-1:0] x;
        input [7:0]    k;
        input          on;
        reg   [DW+16:0] p;
        begin
            p = $signed(x) * $signed({1'b0, frac_gain(k[3:0])}); // R10
            p = $signed(p) >>> (15 + k[7:4]);
            attenuate = on ? p[DW-1:0] : {DW{1'b0}}; // R9
        end
    endfunction

    // One step to target
    function [7:0] slew;
        input [7:0] cur;
        input [7:0] tgt;
        begin
            if (cur < tgt)
                slew = cur + 8'h01;
            else if (cur > tgt)
                slew = cur - 8'h01;
            else
                slew = cur;
        end
    endfunction

    function [3:0] legal_beep;
        input [3:0] g;
        begin
            legal_beep = (g > `RPC_BEEP_MAX) ? `RPC_BEEP_MUTE : g; // R19
        end
    endfunction

    assign pre_l = pre_proc(s_left, dc_l, adc_ctrl[`RPC_B_INVERT], adc_ctrl[`RPC_B_HPF]);
    assign pre_r = pre_proc(s_right, dc_r, adc_ctrl[`RPC_B_INVERT], adc_ctrl[`RPC_B_HPF]);
    assign out_l = attenuate(pre_l, att_cur_l, adc_left_power);
    assign out_r = attenuate(pre_r, att_cur_r, adc_right_power);
    assign beep_pending = (beep_gain_left != legal_beep(beep_l))
                       || (beep_gain_right != legal_beep(beep_r));
    assign pdm_pulse = adc_ctrl[`RPC_B_MIC_POL] ? record_data_line : ~record_data_line; // R5

    always @*
    begin
        case (zc_ctrl[`RPC_B_TMO_HI:`RPC_B_TMO_LO])
            2'h0: timeout = `RPC_TMO_0;
            2'h1: timeout = `RPC_TMO_1;
            2'h2: timeout = `RPC_TMO_2;
            default: timeout = `RPC_TMO_3;
        endcase
    end

    always @*
    begin
        next_readdata = 32'h0000_0000;
        case (idx)
            `RPC_IDX_SLOT:     next_readdata[1:0] = slot_sel;
            `RPC_IDX_ADC_CTRL: next_readdata[6:0] = adc_ctrl;
            `RPC_IDX_ATT_L:    next_readdata[7:0] = att_tgt_l;
            `RPC_IDX_ATT_R:    next_readdata[7:0] = att_tgt_r;
            `RPC_IDX_MIX_L:    next_readdata[5:1] = {dac_left_unmute, beep_l};
            `RPC_IDX_MIX_R:    next_readdata[6:1] = {dac_right_unmute, 1'b0, beep_r};
            `RPC_IDX_BEEP_ZC:  next_readdata[4:0] = {zc_ctrl[2:1], 2'h0, zc_ctrl[0]};
            `RPC_IDX_STATUS:   next_readdata[17:0] = {beep_pending, mic_sel, att_cur_r, att_cur_l};
            default:           next_readdata = 32'h0000_0000;
        endcase
    end

    // Bus slave, one wait cycle
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            avs_waitrequest  <= 1'b1;
            avs_readdata     <= 32'h0000_0000;
            slot_sel         <= `RPC_RST_SLOT;
            adc_ctrl         <= `RPC_RST_ADC_CTRL;
            att_tgt_l        <= `RPC_RST_ATT;
            att_tgt_r        <= `RPC_RST_ATT;
            dac_left_unmute  <= `RPC_RST_DAC_MUTE;
            dac_right_unmute <= `RPC_RST_DAC_MUTE;
            beep_l           <= `RPC_RST_BEEP;
            beep_r           <= `RPC_RST_BEEP;
            zc_ctrl          <= `RPC_RST_BEEP_ZC;
        end
        else
        begin
            avs_waitrequest <= ~((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest)
                avs_readdata <= next_readdata;
            if (wr_lo)
            begin
                case (idx)
                    `RPC_IDX_SLOT:     slot_sel <= avs_writedata[1:0];
                    `RPC_IDX_ADC_CTRL: adc_ctrl <= avs_writedata[6:0];
                    `RPC_IDX_ATT_L:    att_tgt_l <= avs_writedata[7:0];
                    `RPC_IDX_ATT_R:    att_tgt_r <= avs_writedata[7:0];
                    `RPC_IDX_MIX_L:
                    begin
                        dac_left_unmute <= avs_writedata[`RPC_B_MUTE_L]; // R12 R18
                        beep_l <= avs_writedata[`RPC_B_GAIN_HI:`RPC_B_GAIN_LO];
                    end
                    `RPC_IDX_MIX_R:
                    begin
                        dac_right_unmute <= avs_writedata[`RPC_B_MUTE_R]; // R12 R18
                        beep_r <= avs_writedata[`RPC_B_GAIN_HI:`RPC_B_GAIN_LO];
                    end
                    `RPC_IDX_BEEP_ZC:
                        zc_ctrl <= {avs_writedata[`RPC_B_TMO_HI:`RPC_B_TMO_LO],
                                    avs_writedata[`RPC_B_ZC_EN]};
                    default: zc_ctrl <= zc_ctrl;
                endcase
            end
        end
    end

    // Outputs, slew and beep update
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            adc_slot_pair   <= 2'h0;
            adc_left_power  <= 1'b0;
            adc_right_power <= 1'b0;
            att_cur_l       <= `RPC_RST_ATT;
            att_cur_r       <= `RPC_RST_ATT;
            beep_gain_left  <= `RPC_RST_BEEP;
            beep_gain_right <= `RPC_RST_BEEP;
            zc_count        <= 8'h00;
        end
        else
        begin
            adc_slot_pair   <= {slot_sel[1] & tdm_eight_slots, slot_sel[0]}; // R1
            adc_left_power  <= adc_ctrl[`RPC_B_EN_L] & ~mic_sel; // R7 R9
            adc_right_power <= adc_ctrl[`RPC_B_EN_R] & ~mic_sel; // R7 R9
            if (frame_tick)
            begin
                att_cur_l <= slew(att_cur_l, att_tgt_l); // R11
                att_cur_r <= slew(att_cur_r, att_tgt_r); // R11
            end
            if (!beep_pending)
                zc_count <= 8'h00;
            else if (!zc_ctrl[`RPC_B_ZC_EN] || beep_zero_cross || zc_count >= timeout) // R14 R16 R17
            begin
                beep_gain_left  <= legal_beep(beep_l);
                beep_gain_right <= legal_beep(beep_r);
                zc_count        <= 8'h00;
            end
            else if (frame_tick)
                zc_count <= zc_count + 8'h01;
        end
    end

    // Mic clock and capture
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            bclk_cnt     <= 8'h00;
            mic_bclk_out <= 1'b0;
            mic_bclk_oe  <= 1'b0;
            pdm_left     <= 1'b0;
            pdm_right    <= 1'b0;
            pdm_strobe   <= 1'b0;
        end
        else
        begin
            mic_bclk_oe <= mic_sel; // R7
            pdm_strobe  <= 1'b0;
            if (!mic_sel)
            begin
                bclk_cnt     <= 8'h00;
                mic_bclk_out <= 1'b0;
            end
            else if (bclk_cnt == BCLK_HALF[7:0] - 8'h01)
            begin
                bclk_cnt     <= 8'h00;
                mic_bclk_out <= ~mic_bclk_out; // R7
                if (~mic_bclk_out ^ adc_ctrl[`RPC_B_MIC_SWAP]) // R6
                    pdm_left <= pdm_pulse;
                else
                    pdm_right <= pdm_pulse;
                pdm_strobe <= mic_bclk_out;
            end
            else
                bclk_cnt <= bclk_cnt + 8'h01;
        end
    end

    // Two-entry skid buffer
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_ready    <= 1'b0;
            m_valid    <= 1'b0;
            m_left     <= {DW{1'b0}};
            m_right    <= {DW{1'b0}};
            skid_l     <= {DW{1'b0}};
            skid_r     <= {DW{1'b0}};
            skid_valid <= 1'b0;
            dc_l       <= {DW{1'b0}};
            dc_r       <= {DW{1'b0}};
        end
        else
        begin
            if (take && adc_ctrl[`RPC_B_HPF])
            begin
                dc_l <= dc_l + {{HPF_SHIFT{pre_l[DW-1]}}, pre_l[DW-1:HPF_SHIFT]}; // R4
                dc_r <= dc_r + {{HPF_SHIFT{pre_r[DW-1]}}, pre_r[DW-1:HPF_SHIFT]}; // R4
            end
            if (m_ready || !m_valid)
            begin
                s_ready <= 1'b1;
                if (skid_valid)
                begin
                    m_left     <= skid_l;
                    m_right    <= skid_r;
                    m_valid    <= 1'b1;
                    skid_valid <= 1'b0;
                end
                else if (take)
                begin
                    m_left  <= out_l;
                    m_right <= out_r;
                    m_valid <= 1'b1;
                end
                else
                    m_valid <= 1'b0;
            end
            else if (take)
            begin
                skid_l     <= out_l;
                skid_r     <= out_r;
                skid_valid <= 1'b1;
                s_ready    <= 1'b0;
            end
        end
    end
endmodule

// ===== inc/rpc_defs.vh
`ifndef RPC_DEFS_VH
`define RPC_DEFS_VH
// Register indexes; byte address is four times the index
`define RPC_IDX_SLOT       15'h4018
`define RPC_IDX_ADC_CTRL   15'h4019
`define RPC_IDX_ATT_L      15'h401A
`define RPC_IDX_ATT_R      15'h401B
`define RPC_IDX_MIX_L      15'h401C
`define RPC_IDX_MIX_R      15'h401E
`define RPC_IDX_BEEP_ZC    15'h4028
`define RPC_IDX_STATUS     15'h4029
// Reset values
`define RPC_RST_SLOT       2'h0
`define RPC_RST_ADC_CTRL   7'h00
`define RPC_RST_ATT        8'h00
`define RPC_RST_DAC_MUTE   1'h0
`define RPC_RST_BEEP       4'h0
`define RPC_RST_BEEP_ZC    3'h0
// ADC control field positions
`define RPC_B_INVERT       6
`define RPC_B_HPF          5
`define RPC_B_MIC_POL      4
`define RPC_B_MIC_SWAP     3
`define RPC_B_MIC_SEL      2
`define RPC_B_EN_R         1
`define RPC_B_EN_L         0
// Mixer and zero-crossing field positions
`define RPC_B_MUTE_L       5
`define RPC_B_MUTE_R       6
`define RPC_B_GAIN_HI      4
`define RPC_B_GAIN_LO      1
`define RPC_B_ZC_EN        0
`define RPC_B_TMO_HI       4
`define RPC_B_TMO_LO       3
// Beep gain codes
`define RPC_BEEP_MAX       4'h8
`define RPC_BEEP_MUTE      4'h0
// Zero-crossing timeouts in audio frames
`define RPC_TMO_0          8'h04
`define RPC_TMO_1          8'h10
`define RPC_TMO_2          8'h40
`define RPC_TMO_3          8'hFF
// Timing
`define RPC_MCLK_HZ        125000000
`define RPC_FS_HZ          48000
`define RPC_BCLK_RATIO     128
`define RPC_BCLK_HALF      (`RPC_MCLK_HZ / (2 * `RPC_FS_HZ * `RPC_BCLK_RATIO))
// High-pass shift, about 2 Hz at 48 kHz
`define RPC_HPF_SHIFT      12
`endif

// ===== testbench/rpc_regs_checker.sv
`timescale 1ns/1ps
`include "rpc_defs.vh"
module rpc_regs_checker #(
    parameter DW = 24
) (
    input wire          mclk,
    input wire          resetn,
    input wire [16:0]   avs_address,
    input wire          avs_read,
    input wire          avs_write,
    input wire [31:0]   avs_writedata,
    input wire [3:0]    avs_byteenable,
    input wire          avs_waitrequest,
    input wire          tdm_eight_slots,
    input wire          s_valid,
    input wire          s_ready,
    input wire          m_valid,
    input wire          m_ready,
    input wire [DW-1:0] m_left,
    input wire [DW-1:0] m_right,
    input wire [1:0]    adc_slot_pair,
    input wire          adc_left_power,
    input wire          adc_right_power,
    input wire          mic_bclk_oe,
    input wire          dac_left_unmute,
    input wire          dac_right_unmute
);
    wire land = avs_write && !avs_waitrequest && avs_byteenable[0];
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no bus answer");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("wait low when idle");
    a_mute_left: assert property (
        land && avs_address[16:2] == `RPC_IDX_MIX_L |=> dac_left_unmute == $past(avs_writedata[5]))
        else $error("left mute late");
    a_mute_right: assert property (
        land && avs_address[16:2] == `RPC_IDX_MIX_R |=> dac_right_unmute == $past(avs_writedata[6]))
        else $error("right mute late");
    a_slot_four: assert property (
        !tdm_eight_slots && $past(!tdm_eight_slots) |-> !adc_slot_pair[1])
        else $error("upper pair in four slots");
    a_mic_adc_off: assert property (
        mic_bclk_oe && $past(mic_bclk_oe) |-> !adc_left_power && !adc_right_power)
        else $error("ADC on in mic mode");
    a_stream_hold: assert property (
        m_valid && !m_ready |=> m_valid && $stable(m_left) && $stable(m_right))
        else $error("pair changed in stall");
    a_stream_take: assert property (s_valid && s_ready && !m_valid |=> m_valid)
        else $error("pair not presented");
endmodule

bind rpc_record_path_regs rpc_regs_checker #(.DW(DW)) i_rpc_regs_checker (
    .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .tdm_eight_slots(tdm_eight_slots),
    .s_valid(s_valid), .s_ready(s_ready), .m_valid(m_valid), .m_ready(m_ready),
    .m_left(m_left), .m_right(m_right), .adc_slot_pair(adc_slot_pair),
    .adc_left_power(adc_left_power), .adc_right_power(adc_right_power),
    .mic_bclk_oe(mic_bclk_oe), .dac_left_unmute(dac_left_unmute),
    .dac_right_unmute(dac_right_unmute)
);

// ===== testbench/rpc_pdm_mic_model.sv
`timescale 1ns/1ps
module rpc_pdm_mic_model (
    input  wire  mclk,
    input  wire  mic_bclk_out,
    input  wire  mic_bclk_oe,
    input  wire  left_pulse,
    input  wire  right_pulse,
    input  wire  high_active,
    output logic record_data_line
);
    initial record_data_line = 1'b0;
    // Left while clock low, right while high
    always @(posedge mclk)
    begin
        if (!mic_bclk_oe)
            record_data_line <= !record_data_line;
        else if (mic_bclk_out)
            record_data_line <= right_pulse ~^ high_active;
        else
            record_data_line <= left_pulse ~^ high_active;
    end
endmodule

// ===== testbench/test_rpc_record_path_regs.sv
`timescale 1ns/1ps
`include "rpc_defs.vh"
module test_rpc_record_path_regs;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [16:0] avs_address = 17'h00000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        tdm_eight_slots = 1'b1;
    logic        frame_tick = 1'b0;
    logic        beep_zero_cross = 1'b0;
    logic        s_valid = 1'b0;
    logic        m_ready = 1'b1;
    logic [23:0] s_left = 24'h000000;
    logic [23:0] s_right = 24'h000000;
    logic        left_pulse = 1'b1;
    logic        right_pulse = 1'b0;
    logic        high_active = 1'b0;
    logic [31:0] avs_readdata, rd;
    logic [23:0] m_left, m_right;
    logic [3:0]  beep_gain_left, beep_gain_right;
    logic [1:0]  adc_slot_pair;
    logic        avs_waitrequest, record_data_line, s_ready, m_valid, adc_left_power;
    logic        adc_right_power, mic_bclk_out, mic_bclk_oe, pdm_left, pdm_right, pdm_strobe;
    logic        dac_left_unmute, dac_right_unmute;
    int          n_mismatch = 0;
    int          check_count = 0;

    rpc_record_path_regs #(.DW(24), .BCLK_HALF(4)) i_rpc_record_path_regs (
        .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tdm_eight_slots(tdm_eight_slots), .frame_tick(frame_tick),
        .beep_zero_cross(beep_zero_cross), .record_data_line(record_data_line),
        .s_valid(s_valid), .s_ready(s_ready), .s_left(s_left), .s_right(s_right),
        .m_valid(m_valid), .m_ready(m_ready), .m_left(m_left), .m_right(m_right),
        .adc_slot_pair(adc_slot_pair), .adc_left_power(adc_left_power),
        .adc_right_power(adc_right_power), .mic_bclk_out(mic_bclk_out),
        .mic_bclk_oe(mic_bclk_oe), .pdm_left(pdm_left), .pdm_right(pdm_right),
        .pdm_strobe(pdm_strobe), .dac_left_unmute(dac_left_unmute),
        .dac_right_unmute(dac_right_unmute), .beep_gain_left(beep_gain_left),
        .beep_gain_right(beep_gain_right)
    );
    rpc_pdm_mic_model i_rpc_pdm_mic_model (
        .mclk(mclk), .mic_bclk_out(mic_bclk_out), .mic_bclk_oe(mic_bclk_oe),
        .left_pulse(left_pulse), .right_pulse(right_pulse), .high_active(high_active),
        .record_data_line(record_data_line)
    );

    initial
    begin
        forever #4 mclk = ~mclk;
    end

    task check(input logic [47:0] seen, input logic [47:0] exp);
        begin
            check_count++;
            if (seen !== exp)
            begin
                n_mismatch++;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task give_verdict;
        begin
            if (n_mismatch == 0 && check_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    task bus(input logic w, input logic [14:0] idx, input logic [7:0] d);
        begin
            @(posedge mclk);
            avs_address   <= {idx, 2'h0};
            avs_writedata <= {24'h000000, d};
            avs_write     <= w;
            avs_read      <= !w;
            do @(posedge mclk); while (avs_waitrequest !== 1'b0);
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read  <= 1'b0;
        end
    endtask

    task settle;
        repeat (2) @(negedge mclk);
    endtask

    task tick(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            frame_tick <= 1'b1;
            @(posedge mclk);
            frame_tick <= 1'b0;
        end
    endtask

    task t_reset_values;
        logic [14:0] idx [8];
        begin
            idx = '{`RPC_IDX_SLOT, `RPC_IDX_ADC_CTRL, `RPC_IDX_ATT_L, `RPC_IDX_ATT_R,
                    `RPC_IDX_MIX_L, `RPC_IDX_MIX_R, `RPC_IDX_BEEP_ZC, 15'h4030};
            check({dac_left_unmute, dac_right_unmute, beep_gain_left, beep_gain_right}, 0);
            check({adc_left_power, adc_right_power, mic_bclk_oe}, 0);
            foreach (idx[i])
            begin
                bus(1'b0, idx[i], 8'h00);
                check(rd, 0);
            end
            bus(1'b1, 15'h4030, 8'h5A);
            bus(1'b0, 15'h4030, 8'h00);
            check(rd, 0);
            avs_byteenable <= 4'hE;
            bus(1'b1, `RPC_IDX_SLOT, 8'h01);
            avs_byteenable <= 4'hF;
            bus(1'b0, `RPC_IDX_SLOT, 8'h00);
            check(rd, 0);
        end
    endtask

    task t_slot;
        begin
            for (int p = 0; p < 4; p++)
            begin
                bus(1'b1, `RPC_IDX_SLOT, 8'(p));
                settle;
                check(adc_slot_pair, p);
            end
            bus(1'b1, `RPC_IDX_SLOT, 8'hFF);
            bus(1'b0, `RPC_IDX_SLOT, 8'h00);
            check(rd, 3);
            @(posedge mclk);
            tdm_eight_slots <= 1'b0;
            settle;
            check(adc_slot_pair, 1);
            @(posedge mclk);
            tdm_eight_slots <= 1'b1;
        end
    endtask

    task t_mute_beep;
        begin
            bus(1'b1, `RPC_IDX_MIX_L, 8'h20);
            settle;
            check({dac_left_unmute, dac_right_unmute}, 2);
            bus(1'b1, `RPC_IDX_MIX_R, 8'h50);
            settle;
            check({dac_left_unmute, dac_right_unmute, beep_gain_right}, 6'h38);
            bus(1'b1, `RPC_IDX_MIX_L, 8'h42);
            settle;
            check({dac_left_unmute, beep_gain_left}, 1);
            bus(1'b1, `RPC_IDX_BEEP_ZC, 8'h01);
            bus(1'b1, `RPC_IDX_MIX_L, 8'h24);
            tick(3);
            settle;
            check(beep_gain_left, 1);
            tick(1);
            settle;
            check(beep_gain_left, 2);
            bus(1'b1, `RPC_IDX_MIX_L, 8'h26);
            settle;
            check(beep_gain_left, 2);
            @(posedge mclk);
            beep_zero_cross <= 1'b1;
            @(posedge mclk);
            beep_zero_cross <= 1'b0;
            settle;
            check(beep_gain_left, 3);
            bus(1'b1, `RPC_IDX_BEEP_ZC, 8'h00);
            bus(1'b1, `RPC_IDX_MIX_L, 8'h32);
            settle;
            check(beep_gain_left, 0);
        end
    endtask

    task t_mic;
        int n;
        logic b;
        begin
            for (int e = 0; e < 4; e++)
            begin
                bus(1'b1, `RPC_IDX_ADC_CTRL, 8'(e));
                settle;
                check({adc_left_power, adc_right_power}, {e[0], e[1]});
            end
            bus(1'b1, `RPC_IDX_ADC_CTRL, 8'h07);
            settle;
            check({adc_left_power, adc_right_power, mic_bclk_oe}, 1);
            n = 0;
            b = mic_bclk_out;
            repeat (16)
            begin
                @(negedge mclk);
                n += (mic_bclk_out !== b);
                b = mic_bclk_out;
            end
            check(n, 4);
            for (int c = 0; c < 4; c++)
            begin
                bus(1'b1, `RPC_IDX_ADC_CTRL, {3'h0, c[1], c[0], 3'h4});
                high_active <= c[1];
                repeat (3) do @(posedge mclk); while (pdm_strobe !== 1'b1);
                check({pdm_left, pdm_right}, c[0] ? 1 : 2);
            end
            bus(1'b1, `RPC_IDX_ADC_CTRL, 8'h03);
        end
    endtask

    task xfer(input logic [7:0] ctrl, input logic [23:0] el, input logic [23:0] er);
        begin
            bus(1'b1, `RPC_IDX_ADC_CTRL, ctrl);
            @(posedge mclk);
            s_left  <= 24'h012345;
            s_right <= 24'h054321;
            s_valid <= 1'b1;
            do @(posedge mclk); while (s_ready !== 1'b1);
            s_valid <= 1'b0;
            do @(posedge mclk); while (m_valid !== 1'b1);
            check({m_left, m_right}, {el, er});
        end
    endtask

    task t_buffer;
        int k, n;
        begin
            k = 0;
            n = 0;
            @(posedge mclk);
            m_ready <= 1'b0;
            s_left  <= 24'h000010;
            s_valid <= 1'b1;
            repeat (8)
            begin
                @(posedge mclk);
                if (s_ready === 1'b1)
                begin
                    k++;
                    s_left <= 24'h000010 + 24'(k);
                end
            end
            s_valid <= 1'b0;
            m_ready <= 1'b1;
            check(k, 2);
            repeat (6)
            begin
                @(posedge mclk);
                if (m_valid === 1'b1)
                begin
                    check(m_left, 24'h000010 + 24'(n));
                    n++;
                end
            end
            check(n, 2);
        end
    endtask

    task t_slew;
        begin
            bus(1'b1, `RPC_IDX_ATT_L, 8'h03);
            for (int k = 0; k < 8; k++)
            begin
                bus(1'b0, `RPC_IDX_STATUS, 8'h00);
                check(rd[15:0], 16'(k < 4 ? (k < 3 ? k : 3) : 7 - k));
                if (k == 4)
                    bus(1'b1, `RPC_IDX_ATT_L, 8'h00);
                tick(1);
            end
        end
    endtask

    initial
    begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_reset_values;
        t_slot;
        t_mute_beep;
        t_mic;
        xfer(8'h03, 24'h012345, 24'h054321);
        xfer(8'h43, 24'hFEDCBB, 24'hFABCDF);
        xfer(8'h23, 24'h012345, 24'h054321);
        xfer(8'h23, 24'h012333, 24'h0542CD);
        xfer(8'h01, 24'h012345, 24'h000000);
        t_buffer;
        t_slew;
        give_verdict;
    end

    initial
    begin
        #(20000 * 8);
        n_mismatch++;
        give_verdict;
    end
endmodule
